// file: core/qenc_pkg.sv
// qenc_pkg: constants, register map and carrier types for the quadrature encoder counter
// assumes a single 200 MHz clock and an axi4-lite register slave
package qenc_pkg;
   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] QENC_OFS_GLOBAL = 8'h00;
   localparam logic [7:0] QENC_OFS_MODE = 8'h04;
   localparam logic [7:0] QENC_OFS_POS = 8'h08;
   localparam logic [7:0] QENC_OFS_STEP = 8'h0C;
   localparam logic [7:0] QENC_OFS_FLAGS = 8'h10;
   localparam logic [7:0] QENC_OFS_SNAP = 8'h14;
   localparam logic [7:0] QENC_OFS_IRQ_EN = 8'h18;
   localparam logic [7:0] QENC_OFS_IRQ_CLR = 8'h1C;

   // ************************************************************
   // mode register bit positions
   // ************************************************************
   localparam int QENC_MODE_POL_A = 0;
   localparam int QENC_MODE_POL_B = 1;
   localparam int QENC_MODE_POL_N = 2;
   localparam int QENC_MODE_IGNORE_AB = 3;
   localparam int QENC_MODE_CLR_CONT = 4;
   localparam int QENC_MODE_CLR_ONCE = 5;
   localparam int QENC_MODE_LATCH_ONLY = 6;
   localparam int QENC_MODE_DECIMAL = 7;
   localparam int QENC_MODE_INV_A = 8;
   localparam int QENC_MODE_INV_B = 9;
   localparam int QENC_MODE_W = 10;

   // event flag bits
   localparam int QENC_FLAG_N_EVENT = 0;
   localparam int QENC_FLAG_W = 1;

   // ************************************************************
   // reset values and timing
   // ************************************************************
   localparam logic [QENC_MODE_W-1:0] QENC_MODE_RST = 10'h000;
   localparam logic [31:0] QENC_STEP_RST = 32'h00010000;
   localparam logic QENC_GLOBAL_RST = 1'b0;
   localparam int QENC_CLK_MHZ = 200;
   localparam int QENC_FILT_CYC = 3;
   localparam logic [15:0] QENC_DEC_LIMIT = 16'h2710;
   localparam logic [1:0] QENC_RESP_OKAY = 2'h0;
   localparam logic [1:0] QENC_RESP_SLVERR = 2'h2;

   typedef struct packed {
      logic a;
      logic b;
      logic n;
   } qenc_abn_s;
endpackage

// file: core/qenc_filter.sv
// qenc_filter: one-channel glitch filter, output follows a level held QENC_FILT_CYC cycles
// assumes the input is already synchronous to aclk
`timescale 1ns/1ps
module qenc_filter
   import qenc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic din,
   output logic dout
);
   logic [1:0] cnt_ff;
   logic in_ff;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         in_ff <= 1'b0;
         cnt_ff <= 2'h0;
         dout <= 1'b0;
      end else begin
         in_ff <= din;
         if (in_ff == dout) begin
            cnt_ff <= 2'h0;
         end else if (cnt_ff == 2'(QENC_FILT_CYC - 1)) begin
            cnt_ff <= 2'h0;
            dout <= in_ff; // R12
         end else begin
            cnt_ff <= cnt_ff + 2'h1;
         end
      end
   end
endmodule

// file: core/qenc_top.sv
// qenc_top: abn quadrature encoder counter with axi4-lite registers and one interrupt
// assumes abn inputs are synchronous to aclk; one register access of each kind at a time
// Overview of operation
// [R1] continuous mode clears or latches on every accepted index event
// [R2] single-shot mode acts on next accepted index event then disarms itself
// [R3] index events accepted only while a and b match their qualifying polarity; with QENC_MODE_IGNORE_AB set they are accepted at any a, b level
// [R4] each a or b change adds or subtracts the step by decoded direction
// [R5] step constant is signed 16.16 fixed point
// [R6] decimal mode: low half counts ten-thousandths, software keeps it below 10000
// [R7] negative step reverses effective counting direction
// [R8] position always readable; a, b, n polarity selectable
// [R9] index-triggered clear recorded in the event flags register
// [R10] accepted index event in continuous or single-shot mode copies position into the snapshot register
// [R11] counting up to one third of clock rate; encoder must stay below
// [R12] a, b, n filtered, spikes under three clocks rejected
// [R13] global config selects pins as encoder inputs; index use optional
// [R14] gray-code decode, a double transition counts nothing
`timescale 1ns/1ps
module qenc_top
   import qenc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire qenc_abn_s enc_in,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic irq
);
   // ************************************************************
   // registers
   // ************************************************************
   logic global_peripheral_config_ff;
   logic [QENC_MODE_W-1:0] encoder_mode_config_ff;
   logic [31:0] encoder_step_increment_ff;
   logic [31:0] encoder_position_count_ff;
   logic [15:0] pos_frac_ff;
   logic [31:0] encoder_position_snapshot_ff;
   logic [QENC_FLAG_W-1:0] encoder_event_flags_ff;
   logic [QENC_FLAG_W-1:0] irq_en_ff;
   logic [7:0] awaddr_ff;
   logic aw_got_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   logic w_got_ff;

   // ************************************************************
   // input filtering
   // ************************************************************
   qenc_abn_s filt;

   qenc_filter u_filt_a (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(enc_in.a),
      .dout(filt.a)
   ); // R12
   qenc_filter u_filt_b (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(enc_in.b),
      .dout(filt.b)
   ); // R11
   qenc_filter u_filt_n (
      .aclk(aclk),
      .aresetn(aresetn),
      .din(enc_in.n),
      .dout(filt.n)
   );

   // ************************************************************
   // polarity, direction decode and index qualification
   // ************************************************************
   logic a_lvl, b_lvl, n_lvl;
   logic a_prev_ff, b_prev_ff, n_prev_ff;
   logic step_evt, step_up, n_edge, n_accept, n_armed;
   logic [1:0] ab_now, ab_old;

   // pins count only while routed to the encoder
   assign a_lvl = global_peripheral_config_ff & (filt.a ^ encoder_mode_config_ff[QENC_MODE_INV_A]); // R13 R8
   assign b_lvl = global_peripheral_config_ff & (filt.b ^ encoder_mode_config_ff[QENC_MODE_INV_B]); // R8
   assign n_lvl = global_peripheral_config_ff & (filt.n ^ encoder_mode_config_ff[QENC_MODE_POL_N]); // R8
   assign ab_now = {a_lvl, b_lvl};
   assign ab_old = {a_prev_ff, b_prev_ff};

   always_comb begin
      step_evt = 1'b0;
      step_up = 1'b0;
      case ({ab_old, ab_now}) // R14
         4'b0001, 4'b0111, 4'b1110, 4'b1000: begin
            step_evt = 1'b1;
            step_up = 1'b1;
         end
         4'b0010, 4'b1011, 4'b1101, 4'b0100: begin
            step_evt = 1'b1;
            step_up = 1'b0;
         end
         default: begin
            step_evt = 1'b0;
            step_up = 1'b0;
         end
      endcase
   end

   assign n_edge = n_lvl & ~n_prev_ff;
   assign n_accept = n_edge & (encoder_mode_config_ff[QENC_MODE_IGNORE_AB] |
      ((a_lvl == encoder_mode_config_ff[QENC_MODE_POL_A]) &
       (b_lvl == encoder_mode_config_ff[QENC_MODE_POL_B]))); // R3
   assign n_armed = encoder_mode_config_ff[QENC_MODE_CLR_CONT] |
      encoder_mode_config_ff[QENC_MODE_CLR_ONCE]; // R1 R2

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         a_prev_ff <= 1'b0;
         b_prev_ff <= 1'b0;
         n_prev_ff <= 1'b0;
      end else begin
         a_prev_ff <= a_lvl;
         b_prev_ff <= b_lvl;
         n_prev_ff <= n_lvl;
      end
   end

   // ************************************************************
   // position accumulator
   // ************************************************************
   logic [15:0] inc_frac, nxt_frac;
   logic [31:0] nxt_pos;
   logic [16:0] frac_sum;
   logic [15:0] frac_mag;
   logic neg_step, add_dir, carry;
   logic [15:0] step_int;

   always_comb begin
      neg_step = encoder_step_increment_ff[31]; // R7
      add_dir = step_up ^ neg_step; // R4 R7
      step_int = encoder_step_increment_ff[31:16];
      inc_frac = encoder_step_increment_ff[15:0];
      frac_mag = 16'h0000;
      frac_sum = 17'h00000;
      carry = 1'b0;
      nxt_frac = pos_frac_ff;
      nxt_pos = encoder_position_count_ff;
      if (encoder_mode_config_ff[QENC_MODE_DECIMAL]) begin
         // decimal: fraction magnitude in ten-thousandths, moved along the sign
         frac_mag = inc_frac; // R6
         if (add_dir) begin
            frac_sum = {1'b0, pos_frac_ff} + {1'b0, frac_mag};
            carry = (frac_sum >= {1'b0, QENC_DEC_LIMIT});
            nxt_frac = carry ? 16'(frac_sum - {1'b0, QENC_DEC_LIMIT}) : frac_sum[15:0];
            nxt_pos = encoder_position_count_ff + {31'h00000000, carry};
         end else begin
            carry = (pos_frac_ff < frac_mag);
            nxt_frac = carry ? 16'(pos_frac_ff + QENC_DEC_LIMIT - frac_mag) :
               16'(pos_frac_ff - frac_mag);
            nxt_pos = encoder_position_count_ff - {31'h00000000, carry};
         end
         nxt_pos = step_up ? nxt_pos + 32'(signed'(step_int)) :
            nxt_pos - 32'(signed'(step_int)); // R7
      end else begin
         // binary 16.16: full 48-bit signed add split over two registers
         if (step_up) begin
            {nxt_pos, nxt_frac} = {encoder_position_count_ff, pos_frac_ff} +
               {{16{encoder_step_increment_ff[31]}}, encoder_step_increment_ff}; // R5
         end else begin
            {nxt_pos, nxt_frac} = {encoder_position_count_ff, pos_frac_ff} -
               {{16{encoder_step_increment_ff[31]}}, encoder_step_increment_ff}; // R5
         end
      end
   end

   logic n_act, n_clear;
   assign n_act = n_accept & n_armed;
   assign n_clear = n_act & ~encoder_mode_config_ff[QENC_MODE_LATCH_ONLY];

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         encoder_position_count_ff <= 32'h00000000;
         pos_frac_ff <= 16'h0000;
      end else if (n_clear) begin
         encoder_position_count_ff <= 32'h00000000; // R1 R2
         pos_frac_ff <= 16'h0000;
      end else if (step_evt) begin
         encoder_position_count_ff <= nxt_pos; // R4 R8
         pos_frac_ff <= nxt_frac;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         encoder_position_snapshot_ff <= 32'h00000000;
      end else if (n_act) begin
         encoder_position_snapshot_ff <= encoder_position_count_ff; // R10
      end
   end

   // ************************************************************
   // axi4-lite write path and control registers
   // ************************************************************
   logic wr_fire;
   logic [31:0] wmask;
   assign wr_fire = aw_got_ff & w_got_ff & ~s_axi_bvalid;
   assign wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}}, {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_got_ff <= 1'b0;
         w_got_ff <= 1'b0;
         awaddr_ff <= 8'h00;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= QENC_RESP_OKAY;
      end else begin
         s_axi_awready <= ~aw_got_ff & ~s_axi_awready & s_axi_awvalid;
         s_axi_wready <= ~w_got_ff & ~s_axi_wready & s_axi_wvalid;
         if (s_axi_awvalid & s_axi_awready) begin
            aw_got_ff <= 1'b1;
            awaddr_ff <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            w_got_ff <= 1'b1;
            wdata_ff <= s_axi_wdata;
            wstrb_ff <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            case (awaddr_ff)
               QENC_OFS_GLOBAL, QENC_OFS_MODE, QENC_OFS_STEP, QENC_OFS_IRQ_EN,
               QENC_OFS_IRQ_CLR: s_axi_bresp <= QENC_RESP_OKAY;
               default: s_axi_bresp <= QENC_RESP_SLVERR;
            endcase
         end else if (s_axi_bvalid & s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   logic wr_mode, wr_step;
   assign wr_mode = wr_fire & (awaddr_ff == QENC_OFS_MODE);
   assign wr_step = wr_fire & (awaddr_ff == QENC_OFS_STEP);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         global_peripheral_config_ff <= QENC_GLOBAL_RST;
         encoder_step_increment_ff <= QENC_STEP_RST;
         irq_en_ff <= '0;
      end else if (wr_fire) begin
         if (awaddr_ff == QENC_OFS_GLOBAL && wstrb_ff[0]) begin
            global_peripheral_config_ff <= wdata_ff[0]; // R13
         end
         if (wr_step) begin
            encoder_step_increment_ff <= (wdata_ff & wmask) |
               (encoder_step_increment_ff & ~wmask); // R5 R6
         end
         if (awaddr_ff == QENC_OFS_IRQ_EN && wstrb_ff[0]) begin
            irq_en_ff <= wdata_ff[QENC_FLAG_W-1:0];
         end
      end
   end

   logic [QENC_MODE_W-1:0] mode_wr;
   assign mode_wr = (wdata_ff[QENC_MODE_W-1:0] & wmask[QENC_MODE_W-1:0]) |
      (encoder_mode_config_ff & ~wmask[QENC_MODE_W-1:0]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         encoder_mode_config_ff <= QENC_MODE_RST;
      end else if (wr_mode) begin
         encoder_mode_config_ff <= mode_wr;
      end else if (n_act) begin
         encoder_mode_config_ff[QENC_MODE_CLR_ONCE] <= 1'b0; // R2
      end
   end

   // ************************************************************
   // event flags and interrupt
   // ************************************************************
   logic [QENC_FLAG_W-1:0] flag_set, flag_clr;
   assign flag_set = n_act ? 1'b1 : 1'b0;
   assign flag_clr = (wr_fire && awaddr_ff == QENC_OFS_IRQ_CLR && wstrb_ff[0]) ?
      wdata_ff[QENC_FLAG_W-1:0] : '0;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         encoder_event_flags_ff <= '0;
         irq <= 1'b0;
      end else begin
         encoder_event_flags_ff <= (encoder_event_flags_ff & ~flag_clr) | flag_set; // R9
         irq <= |(((encoder_event_flags_ff & ~flag_clr) | flag_set) & irq_en_ff);
      end
   end

   // ************************************************************
   // axi4-lite read path
   // ************************************************************
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= QENC_RESP_OKAY;
      end else begin
         s_axi_arready <= ~s_axi_rvalid & ~s_axi_arready & s_axi_arvalid;
         if (s_axi_arvalid & s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= QENC_RESP_OKAY;
            case (s_axi_araddr)
               QENC_OFS_GLOBAL: s_axi_rdata <= {31'h00000000, global_peripheral_config_ff};
               QENC_OFS_MODE: s_axi_rdata <= {22'h000000, encoder_mode_config_ff};
               QENC_OFS_POS: s_axi_rdata <= encoder_position_count_ff; // R8
               QENC_OFS_STEP: s_axi_rdata <= encoder_step_increment_ff;
               QENC_OFS_FLAGS: s_axi_rdata <= {31'h00000000, encoder_event_flags_ff}; // R9
               QENC_OFS_SNAP: s_axi_rdata <= encoder_position_snapshot_ff;
               QENC_OFS_IRQ_EN: s_axi_rdata <= {31'h00000000, irq_en_ff};
               QENC_OFS_IRQ_CLR: s_axi_rdata <= 32'h00000000;
               default: begin
                  s_axi_rdata <= 32'h00000000;
                  s_axi_rresp <= QENC_RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid & s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end
endmodule

// file: bench/qenc_properties.sv
// qenc_properties: bus handshake and interrupt checks on the encoder counter ports
// assumes it is bound to qenc_top and that everything runs on aclk
`timescale 1ns/1ps
module qenc_properties
   import qenc_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire qenc_abn_s enc_in,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // ************************************************************
   // cycles since the index pin or a write last moved
   // ************************************************************
   logic [3:0] n_age_ff;
   logic [3:0] w_age_ff;
   always_ff @(posedge aclk) begin
      if (!aresetn || !$stable(enc_in.n)) n_age_ff <= 4'h0;
      else if (n_age_ff != 4'hF) n_age_ff <= n_age_ff + 4'h1;
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) w_age_ff <= 4'hF;
      else if (s_axi_wvalid && s_axi_wready) w_age_ff <= 4'h0;
      else if (w_age_ff != 4'hF) w_age_ff <= w_age_ff + 4'h1;
   end
   // ************************************************************
   // properties
   // ************************************************************
   sequence s_wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence s_rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   property p_wr_answer;
      s_wr_taken |-> ##[1:3] s_axi_bvalid;
   endproperty
   property p_rd_answer;
      s_rd_taken |=> s_axi_rvalid;
   endproperty
   property p_rd_hold;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   property p_wr_hold;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   property p_ar_take;
      s_axi_arvalid && !s_axi_rvalid |-> ##[0:3] s_axi_arready;
   endproperty
   property p_aw_pulse;
      s_axi_awready |=> !s_axi_awready;
   endproperty
   property p_err_zero;
      s_axi_rvalid && s_axi_rresp == QENC_RESP_SLVERR |-> s_axi_rdata == 32'h0;
   endproperty
   property p_irq_rise;
      $rose(irq) |-> n_age_ff <= 4'hC || w_age_ff <= 4'h6;
   endproperty
   property p_irq_fall;
      $fell(irq) |-> w_age_ff <= 4'h6;
   endproperty
   property p_rst_quiet;
      disable iff (1'b0) !aresetn |=> !s_axi_bvalid && !s_axi_rvalid && !irq;
   endproperty
   a_wr_answer: assert property (p_wr_answer)
      else $error("write response late");
   a_rd_answer: assert property (p_rd_answer)
      else $error("read data late");
   a_rd_hold: assert property (p_rd_hold)
      else $error("read data dropped early");
   a_wr_hold: assert property (p_wr_hold)
      else $error("write response dropped early");
   a_ar_take: assert property (p_ar_take)
      else $error("read address not taken");
   a_aw_pulse: assert property (p_aw_pulse)
      else $error("awready longer than one cycle");
   a_err_zero: assert property (p_err_zero)
      else $error("error read carries data");
   a_irq_rise: assert property (p_irq_rise)
      else $error("interrupt rose without cause");
   a_irq_fall: assert property (p_irq_fall)
      else $error("interrupt fell without write");
   a_rst_quiet: assert property (p_rst_quiet)
      else $error("outputs active after reset");
endmodule
bind qenc_top qenc_properties u_props (.*);

// file: bench/qenc_encoder_model.sv
// qenc_encoder_model: behavioural abn encoder driving gray-coded a/b and an index pulse
// assumes the bench calls its tasks one at a time, just after a clock edge
`timescale 1ns/1ps
module qenc_encoder_model
   import qenc_pkg::*;
(
   input wire logic aclk,
   output qenc_abn_s abn
);
   logic [1:0] ph = 2'h0;
   initial abn = '0;
   // one quadrature step, levels held well past the filter time
   task automatic move(input logic up);
      ph = up ? ph + 2'h1 : ph - 2'h1;
      @(posedge aclk);
      {abn.a, abn.b} <= ph ^ (ph >> 1);
      repeat (6) @(posedge aclk);
   endtask
   // both channels change at once
   task automatic jump();
      ph = ph + 2'h2;
      @(posedge aclk);
      {abn.a, abn.b} <= ph ^ (ph >> 1);
      repeat (6) @(posedge aclk);
   endtask
   // a spike on a shorter than the filter time
   task automatic glitch();
      @(posedge aclk);
      abn.a <= ~abn.a;
      repeat (2) @(posedge aclk);
      abn.a <= ~abn.a;
      repeat (6) @(posedge aclk);
   endtask
   task automatic pulse_n(input int width);
      @(posedge aclk);
      abn.n <= 1'b1;
      repeat (width) @(posedge aclk);
      abn.n <= 1'b0;
      repeat (8) @(posedge aclk);
   endtask
endmodule

// file: bench/testbench.sv
// testbench: register and encoder scenarios for qenc_top
// assumes qenc_encoder_model on enc_in and the bound property checker
`timescale 1ns/1ps
module testbench;
   import qenc_pkg::*;
   logic aclk, aresetn;
   qenc_abn_s enc_in;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
   logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, irq;
   int miscompares = 0;
   int total_checks = 0;
   logic [41:0] rows [9];
   qenc_top uut (.*);
   qenc_encoder_model enc (.aclk(aclk), .abn(enc_in));
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // ************************************************************
   // report and compare
   // ************************************************************
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // ************************************************************
   // axi4-lite master
   // ************************************************************
   task automatic wrc(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
      int k;
      @(posedge aclk);
      s_axi_awaddr <= ad;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) break;
      end
      s_axi_bready <= 1'b0;
      if (k == 40) begin
         miscompares++;
         tally_and_finish();
      end
      chk_word({30'h0, s_axi_bresp}, {30'h0, er});
   endtask
   task automatic rdc(input logic [7:0] ad, input logic [31:0] exp, input logic [1:0] er);
      int k;
      @(posedge aclk);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 40; k++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) break;
      end
      s_axi_rready <= 1'b0;
      if (k == 40) begin
         miscompares++;
         tally_and_finish();
      end
      chk_word(s_axi_rdata, exp);
      chk_word({30'h0, s_axi_rresp}, {30'h0, er});
   endtask
   task automatic mv(input logic up, input int cnt);
      for (int i = 0; i < cnt; i++) enc.move(up);
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial begin
      rows = '{{8'h00, 32'h0, 2'h0}, {8'h04, 32'h0, 2'h0}, {8'h08, 32'h0, 2'h0},
               {8'h0C, QENC_STEP_RST, 2'h0}, {8'h10, 32'h0, 2'h0}, {8'h14, 32'h0, 2'h0},
               {8'h18, 32'h0, 2'h0}, {8'h1C, 32'h0, 2'h0}, {8'h20, 32'h0, QENC_RESP_SLVERR}};
      aresetn = 1'b0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      s_axi_wstrb = 4'hF;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (int i = 0; i < 9; i++) rdc(rows[i][41:34], rows[i][33:2], rows[i][1:0]);
      $display("test end: reset values");
      wrc(8'h00, 32'h1, 2'h0);
      wrc(8'h18, 32'h1, 2'h0);
      mv(1'b1, 4);
      rdc(8'h08, 32'h4, 2'h0);
      mv(1'b0, 2);
      rdc(8'h08, 32'h2, 2'h0);
      enc.jump();
      enc.glitch();
      rdc(8'h08, 32'h2, 2'h0);
      wrc(8'h08, 32'h0, QENC_RESP_SLVERR);
      $display("test end: counting");
      wrc(8'h04, 32'h53, 2'h0);
      enc.pulse_n(4);
      rdc(8'h10, 32'h0, 2'h0);
      mv(1'b1, 2);
      enc.pulse_n(4);
      rdc(8'h10, 32'h1, 2'h0);
      rdc(8'h14, 32'h4, 2'h0);
      rdc(8'h08, 32'h4, 2'h0);
      chk_word({31'h0, irq}, 32'h1);
      mv(1'b1, 4);
      enc.pulse_n(4);
      rdc(8'h14, 32'h8, 2'h0);
      wrc(8'h1C, 32'h1, 2'h0);
      rdc(8'h10, 32'h0, 2'h0);
      chk_word({31'h0, irq}, 32'h0);
      $display("test end: continuous index");
      wrc(8'h04, 32'h23, 2'h0);
      enc.pulse_n(4);
      rdc(8'h08, 32'h0, 2'h0);
      rdc(8'h14, 32'h8, 2'h0);
      mv(1'b1, 4);
      enc.pulse_n(4);
      rdc(8'h08, 32'h4, 2'h0);
      rdc(8'h04, 32'h3, 2'h0);
      $display("test end: single index");
      wrc(8'h0C, 32'hFFFF0000, 2'h0);
      mv(1'b1, 4);
      rdc(8'h08, 32'h0, 2'h0);
      wrc(8'h0C, 32'h00008000, 2'h0);
      mv(1'b1, 3);
      rdc(8'h08, 32'h1, 2'h0);
      mv(1'b1, 1);
      wrc(8'h04, 32'h80, 2'h0);
      wrc(8'h0C, 32'h00001388, 2'h0);
      mv(1'b1, 4);
      rdc(8'h08, 32'h4, 2'h0);
      wrc(8'h0C, 32'hFFFF1388, 2'h0);
      mv(1'b1, 2);
      rdc(8'h08, 32'h1, 2'h0);
      wrc(8'h00, 32'h0, 2'h0);
      mv(1'b0, 4);
      rdc(8'h08, 32'h1, 2'h0);
      $display("test end: step formats");
      @(posedge aclk);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      rdc(8'h08, 32'h0, 2'h0);
      rdc(8'h00, 32'h0, 2'h0);
      rdc(8'h04, 32'h0, 2'h0);
      $display("test end: mid-run reset");
      tally_and_finish();
   end
endmodule
